//--- logic/dmaes_pkg.sv
package dmaes_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 4;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CMD = 4'h8;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int unsigned BIT_TX_DONE = 0;
  localparam int unsigned BIT_TX_STOP = 1;
  localparam int unsigned BIT_TX_UNAV = 2;
  localparam int unsigned BIT_RX_DONE = 6;
  localparam int unsigned BIT_RX_UNAV = 7;
  localparam int unsigned BIT_RX_STOP = 8;
  localparam int unsigned BIT_RX_WDOG = 9;
  localparam int unsigned BIT_ABN_SUM = 15;
  localparam int unsigned POS_RX_STATE = 17;
  localparam int unsigned POS_TX_STATE = 20;
  localparam int unsigned STATE_W = 3;

  localparam logic [DATA_W-1:0] FLAG_BITS = 32'h000003C7;
  localparam logic [DATA_W-1:0] ABN_BITS = 32'h00000182;
  localparam logic [DATA_W-1:0] MASK_BITS = 32'h000083C7;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;

  // ----------------------------------------
  // Command bits (write one to issue)
  // ----------------------------------------
  localparam int unsigned BIT_CMD_TX_POLL = 0;
  localparam int unsigned BIT_CMD_RX_POLL = 1;

  // ----------------------------------------
  // Process state codes
  // ----------------------------------------
  localparam logic [STATE_W-1:0] ST_STOPPED = 3'h0;
  localparam logic [STATE_W-1:0] TX_ST_SUSP = 3'h6;
  localparam logic [STATE_W-1:0] RX_ST_SUSP = 3'h4;

  // ----------------------------------------
  // Receive watchdog window in bytes
  // ----------------------------------------
  localparam int unsigned WDOG_MIN = 2048;
  localparam int unsigned WDOG_MAX = 2560;
  localparam int unsigned WDOG_CNT_W = 12;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} dmaes_bus_t;

endpackage

//--- logic/dmaes_flag_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dmaes_flag_if #(parameter int unsigned W = 32);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] mask;
  logic [W-1:0] status;
  logic irq;

  modport ctrl (output set, output clr, output mask, input status, input irq);
  modport bank (input set, input clr, input mask, output status, output irq);
endinterface
`default_nettype wire

//--- logic/dmaes_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
module dmaes_flag_bank #(
  parameter int unsigned W = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  dmaes_flag_if.bank flg
);

  // ----------------------------------------
  // Sticky bits, set beats clear
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
          flg.status[i] <= 1'b0;
        else if (flg.set[i])
          flg.status[i] <= 1'b1;
        else if (flg.clr[i])
          flg.status[i] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt level
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      flg.irq <= 1'b0;
    else
      flg.irq <= |(flg.status & flg.mask);
  end

endmodule
`default_nettype wire

//--- logic/dmaes_top.sv
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dmaes_top #(
  parameter int unsigned WDOG_BYTES = dmaes_pkg::WDOG_MIN
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [dmaes_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [dmaes_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [dmaes_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // Transmit engine
  input wire logic [dmaes_pkg::STATE_W-1:0] tx_state_i,
  input wire logic tx_desc_fetch_i,
  input wire logic tx_desc_dma_owned_i,
  input wire logic tx_frame_sent_i,
  input wire logic tx_descriptor_word1_b31_i,
  output logic tx_suspend_o,
  output logic tx_poll_demand_o,
  output logic [dmaes_pkg::STATE_W-1:0] tx_state_o,
  // Receive engine
  input wire logic [dmaes_pkg::STATE_W-1:0] rx_state_i,
  input wire logic rx_desc_fetch_i,
  input wire logic rx_desc_dma_owned_i,
  input wire logic rx_frame_start_i,
  input wire logic rx_byte_i,
  input wire logic rx_frame_recognised_i,
  input wire logic rx_status_written_i,
  output logic rx_suspend_o,
  output logic rx_resume_o,
  output logic rx_poll_demand_o,
  output logic [dmaes_pkg::STATE_W-1:0] rx_state_o
);
  import dmaes_pkg::*;

  if (WDOG_BYTES < WDOG_MIN || WDOG_BYTES > WDOG_MAX)
  begin : g_chk
    $error("WDOG_BYTES outside the receive watchdog window");
  end

  if (WDOG_MAX >= (1 << WDOG_CNT_W))
  begin : g_chk_cnt
    $error("Watchdog counter too narrow for the window");
  end

  if (DATA_W != 32)
  begin : g_chk_w
    $error("Byte lanes assume a 32-bit data path");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [DATA_W-1:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic entered_stop(input logic [STATE_W-1:0] now,
                                        input logic [STATE_W-1:0] prev);
    entered_stop = (now == ST_STOPPED) && (prev != ST_STOPPED);
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  localparam logic [WDOG_CNT_W-1:0] WDOG_LIMIT = WDOG_CNT_W'(WDOG_BYTES);

  dmaes_flag_if #(.W(DATA_W)) flg ();

  dmaes_flag_bank #(.W(DATA_W)) u_bank (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .flg(flg)
  );

  dmaes_bus_t bus_st;
  logic [DATA_W-1:0] mask;
  logic abn_sum;
  logic [STATE_W-1:0] tx_state_prev;
  logic [STATE_W-1:0] rx_state_prev;
  logic rx_prev_dma_owned;
  logic [WDOG_CNT_W-1:0] rx_len;
  logic rx_wdog_fired;
  logic wr_go;
  logic rd_go;
  logic [DATA_W-1:0] wmask;
  logic tx_host_desc;
  logic rx_host_desc;
  logic rx_wdog_hit;
  logic [DATA_W-1:0] next_set;
  logic [DATA_W-1:0] next_rd;
  logic wr_status;
  logic wr_mask;
  logic wr_cmd;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  assign rd_go = avs_read_i && (bus_st == BUS_IDLE);
  assign wr_go = avs_write_i && (bus_st == BUS_ACK);
  assign wmask = avs_writedata_i & be_mask(avs_byteenable_i);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      bus_st <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      case (bus_st)
        BUS_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            bus_st <= BUS_ACK;
            avs_waitrequest_o <= 1'b0;
          end
        end
        BUS_ACK:
        begin
          bus_st <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default:
        begin
          bus_st <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wr_status = wr_go && addr_is(avs_address_i, OFS_STATUS);
  assign wr_mask = wr_go && addr_is(avs_address_i, OFS_MASK);
  assign wr_cmd = wr_go && addr_is(avs_address_i, OFS_CMD);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    next_rd = '0;
    case (avs_address_i)
      OFS_STATUS:
      begin
        next_rd = flg.status & FLAG_BITS;
        next_rd[BIT_ABN_SUM] = abn_sum;
        next_rd[POS_TX_STATE +: STATE_W] = tx_state_o;
        next_rd[POS_RX_STATE +: STATE_W] = rx_state_o;
      end
      OFS_MASK: next_rd = mask;
      default: next_rd = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= '0;
    else if (rd_go)
      avs_readdata_o <= next_rd;
  end

  // ----------------------------------------
  // Mask and commands
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      mask <= MASK_RESET;
    else if (wr_mask)
      mask <= (mask & ~be_mask(avs_byteenable_i)) | (wmask & MASK_BITS);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_poll_demand_o <= 1'b0;
      rx_poll_demand_o <= 1'b0;
    end
    else
    begin
      tx_poll_demand_o <= wr_cmd && wmask[BIT_CMD_TX_POLL];
      rx_poll_demand_o <= wr_cmd && wmask[BIT_CMD_RX_POLL];
    end
  end

  // ----------------------------------------
  // Flag bank hookup
  // ----------------------------------------
  assign flg.mask = mask;
  assign flg.clr = wr_status ? (wmask & FLAG_BITS) : '0;
  assign flg.set = next_set;

  assign tx_host_desc = tx_desc_fetch_i && !tx_desc_dma_owned_i;
  assign rx_host_desc = rx_desc_fetch_i && !rx_desc_dma_owned_i;
  assign rx_wdog_hit = rx_byte_i && !rx_frame_start_i && !rx_wdog_fired && (rx_len >= WDOG_LIMIT);

  always_comb
  begin
    next_set = '0;
    next_set[BIT_TX_DONE] = tx_frame_sent_i && tx_descriptor_word1_b31_i;
    next_set[BIT_TX_STOP] = entered_stop(tx_state_i, tx_state_prev);
    next_set[BIT_TX_UNAV] = tx_host_desc;
    next_set[BIT_RX_DONE] = rx_status_written_i;
    next_set[BIT_RX_UNAV] = rx_host_desc && rx_prev_dma_owned;
    next_set[BIT_RX_STOP] = entered_stop(rx_state_i, rx_state_prev);
    next_set[BIT_RX_WDOG] = rx_wdog_hit;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      abn_sum <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      abn_sum <= |(flg.status & mask & ABN_BITS);
      irq_o <= flg.irq;
    end
  end

  // ----------------------------------------
  // Stop edge tracking
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_state_prev <= ST_STOPPED;
      rx_state_prev <= ST_STOPPED;
    end
    else
    begin
      tx_state_prev <= tx_state_i;
      rx_state_prev <= rx_state_i;
    end
  end

  // ----------------------------------------
  // Transmit suspension
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      tx_suspend_o <= 1'b0;
    else if (tx_host_desc)
      tx_suspend_o <= 1'b1;
    else if (tx_poll_demand_o || tx_state_i == ST_STOPPED)
      tx_suspend_o <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      tx_state_o <= ST_STOPPED;
    else if (tx_host_desc || (tx_suspend_o && !tx_poll_demand_o && tx_state_i != ST_STOPPED))
      tx_state_o <= TX_ST_SUSP;
    else
      tx_state_o <= tx_state_i;
  end

  // ----------------------------------------
  // Receive suspension
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rx_prev_dma_owned <= 1'b1;
    else if (rx_desc_fetch_i)
      rx_prev_dma_owned <= rx_desc_dma_owned_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rx_suspend_o <= 1'b0;
      rx_resume_o <= 1'b0;
    end
    else
    begin
      rx_resume_o <= 1'b0;
      if (rx_host_desc)
        rx_suspend_o <= 1'b1;
      else if (rx_suspend_o && (rx_poll_demand_o || rx_frame_recognised_i))
      begin
        rx_suspend_o <= 1'b0;
        rx_resume_o <= 1'b1;
      end
      else if (rx_state_i == ST_STOPPED)
        rx_suspend_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rx_state_o <= ST_STOPPED;
    else if (rx_host_desc || (rx_suspend_o && !rx_poll_demand_o && !rx_frame_recognised_i
             && rx_state_i != ST_STOPPED))
      rx_state_o <= RX_ST_SUSP;
    else
      rx_state_o <= rx_state_i;
  end

  // ----------------------------------------
  // Receive length watchdog
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rx_len <= '0;
      rx_wdog_fired <= 1'b0;
    end
    else if (rx_frame_start_i)
    begin
      rx_len <= rx_byte_i ? WDOG_CNT_W'(1) : '0;
      rx_wdog_fired <= 1'b0;
    end
    else if (rx_byte_i)
    begin
      if (rx_len != '1)
        rx_len <= rx_len + WDOG_CNT_W'(1);
      if (rx_wdog_hit)
        rx_wdog_fired <= 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- verification/dmaes_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dmaes_host_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [1:0] give_i,
  input wire logic [1:0] take_i,
  output logic tx_owned_o,
  output logic rx_owned_o
);
  // Owner bits of the next descriptors; host gives them back before any poll
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_owned_o <= 1'b1;
      rx_owned_o <= 1'b1;
    end
    else
    begin
      if (give_i[0]) tx_owned_o <= 1'b1;
      else if (take_i[0]) tx_owned_o <= 1'b0;
      if (give_i[1]) rx_owned_o <= 1'b1;
      else if (take_i[1]) rx_owned_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verification/dmaes_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dmaes_chk_sva #(
  parameter int unsigned WDOG_BYTES = 2048
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [2:0] tx_state_i,
  input wire logic tx_desc_fetch_i,
  input wire logic tx_desc_dma_owned_i,
  input wire logic tx_suspend_o,
  input wire logic [2:0] tx_state_o,
  input wire logic [2:0] rx_state_i,
  input wire logic rx_desc_fetch_i,
  input wire logic rx_desc_dma_owned_i,
  input wire logic rx_frame_recognised_i,
  input wire logic rx_suspend_o,
  input wire logic rx_resume_o,
  input wire logic rx_poll_demand_o,
  input wire logic [2:0] rx_state_o
);
  import dmaes_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_rsvd; !avs_waitrequest_o |-> (avs_readdata_o & 32'hFF817C38) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_txs; tx_desc_fetch_i && !tx_desc_dma_owned_i && tx_state_i != 3'h0 |=> tx_suspend_o;
  endproperty
  a_txs: assert property (p_txs) else $error("tx not suspended");
  property p_txc; tx_suspend_o && $past(tx_suspend_o) |-> tx_state_o == TX_ST_SUSP; endproperty
  a_txc: assert property (p_txc) else $error("tx state code wrong");
  property p_rxs; rx_desc_fetch_i && !rx_desc_dma_owned_i && rx_state_i != 3'h0 |=> rx_suspend_o;
  endproperty
  a_rxs: assert property (p_rxs) else $error("rx not suspended");
  property p_rxc; rx_suspend_o && $past(rx_suspend_o) |-> rx_state_o == RX_ST_SUSP; endproperty
  a_rxc: assert property (p_rxc) else $error("rx state code wrong");
  property p_rxf; rx_suspend_o && rx_frame_recognised_i |-> ##[1:2] rx_resume_o; endproperty
  a_rxf: assert property (p_rxf) else $error("rx no resume on frame");
  property p_rxp; rx_suspend_o && rx_poll_demand_o |-> ##[0:2] !rx_suspend_o; endproperty
  a_rxp: assert property (p_rxp) else $error("rx no resume on poll");
  c_rxp: cover property (rx_suspend_o && rx_poll_demand_o);
  c_rxf: cover property (rx_suspend_o && rx_frame_recognised_i);
  c_txs: cover property (tx_suspend_o);
endmodule
bind dmaes_top dmaes_chk_sva #(.WDOG_BYTES(WDOG_BYTES)) u_chk (.*);
`default_nettype wire

//--- verification/test_dma_event_status_flags.sv
`timescale 1ns/1ns
`default_nettype none
module test_dma_event_status_flags;
  import dmaes_pkg::*;
  localparam int unsigned WB = 2048;
  logic clk_sys_i, rst_n_i, rd, wr, txf, txo, txs, txb, rxf, rxo, rxa, rxb, rxr, rxw;
  logic [3:0] addr;
  logic [31:0] wd, rdat, q;
  logic wt, irq, txsu, txpd, rxsu, rxre, rxpd;
  logic [2:0] txst, rxst, txso, rxso;
  logic [1:0] give, take;
  logic [3:0] be;
  int n_errors, checked, cyc;
  dmaes_top #(.WDOG_BYTES(WB)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq),
    .tx_state_i(txst), .tx_desc_fetch_i(txf), .tx_desc_dma_owned_i(txo),
    .tx_frame_sent_i(txs), .tx_descriptor_word1_b31_i(txb), .tx_suspend_o(txsu),
    .tx_poll_demand_o(txpd), .tx_state_o(txso), .rx_state_i(rxst), .rx_desc_fetch_i(rxf),
    .rx_desc_dma_owned_i(rxo), .rx_frame_start_i(rxa), .rx_byte_i(rxb),
    .rx_frame_recognised_i(rxr), .rx_status_written_i(rxw), .rx_suspend_o(rxsu),
    .rx_resume_o(rxre), .rx_poll_demand_o(rxpd), .rx_state_o(rxso));
  dmaes_host_model u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .give_i(give),
    .take_i(take), .tx_owned_o(txo), .rx_owned_o(rxo));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task give_verdict;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("wait_cycles", 32'h2, n);
  endtask
  task rdchk(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task t_reset;
    rdchk("status", OFS_STATUS, 32'hFFFFFFFF, 32'h0);
    rdchk("unmapped", 4'hC, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    rdchk("reserved", OFS_STATUS, 32'hFFFFFFFF, 32'h0);
  endtask
  task t_tx;
    tk(1); txst <= 3'h1; txs <= 1'b1; tk(1); txs <= 1'b0;
    rdchk("tx_done_unqual", OFS_STATUS, FLAG_BITS, 32'h0);
    tk(1); txs <= 1'b1; txb <= 1'b1; tk(1); txs <= 1'b0;
    rdchk("tx_done", OFS_STATUS, FLAG_BITS, 32'h1);
    tk(1); txst <= 3'h0; tk(1); txst <= 3'h1;
    rdchk("tx_stop", OFS_STATUS, FLAG_BITS, 32'h3);
    tk(1); take <= 2'h1; tk(1); take <= 2'h0; txf <= 1'b1; tk(1); txf <= 1'b0;
    tk(2); chk("tx_state_o", {29'h0, TX_ST_SUSP}, {29'h0, txso});
    rdchk("tx_unav", OFS_STATUS, FLAG_BITS, 32'h7);
    tk(1); give <= 2'h1; tk(1); give <= 2'h0;
    bus(1'b1, OFS_CMD, 32'h1);
    tk(1); chk("tx_poll", 32'h1, txpd);
    tk(1); chk("tx_suspend", 32'h0, txsu);
    bus(1'b1, OFS_STATUS, 32'h7);
    rdchk("tx_clear", OFS_STATUS, FLAG_BITS, 32'h0);
  endtask
  task t_rx;
    tk(1); rxst <= 3'h3; take <= 2'h2; tk(1); take <= 2'h0; rxf <= 1'b1; tk(1); rxf <= 1'b0;
    tk(2); chk("rx_state_o", {29'h0, RX_ST_SUSP}, {29'h0, rxso});
    chk("rx_suspend", 1, rxsu);
    bus(1'b1, OFS_STATUS, 32'h0);
    tk(20); rdchk("rx_unav_held", OFS_STATUS, FLAG_BITS, 32'h80);
    bus(1'b1, OFS_STATUS, 32'h80);
    tk(1); rxf <= 1'b1; tk(1); rxf <= 1'b0;
    rdchk("rx_unav_again", OFS_STATUS, FLAG_BITS, 32'h0);
    tk(1); rxr <= 1'b1; tk(1); rxr <= 1'b0;
    tk(1); chk("rx_frame_resume_pulse", 32'h1, rxre);
    tk(1); chk("rx_frame_resume", 32'h0, rxsu);
    tk(1); rxw <= 1'b1; tk(1); rxw <= 1'b0;
    rdchk("rx_done", OFS_STATUS, FLAG_BITS, 32'h40);
    tk(1); rxf <= 1'b1; tk(1); rxf <= 1'b0; give <= 2'h2; tk(1); give <= 2'h0;
    bus(1'b1, OFS_CMD, 32'h2);
    tk(1); chk("rx_poll", 32'h1, rxpd);
    tk(1); chk("rx_resume", 32'h1, rxre);
    chk("rx_poll_resume", 32'h0, rxsu);
    tk(1); rxst <= 3'h0;
    rdchk("rx_stop", OFS_STATUS, FLAG_BITS, 32'h140);
    bus(1'b1, OFS_STATUS, 32'h140);
  endtask
  task t_wdog;
    tk(1); rxst <= 3'h3; rxa <= 1'b1; rxb <= 1'b1; tk(1); rxa <= 1'b0; tk(WB - 1); rxb <= 1'b0;
    rdchk("wdog_limit", OFS_STATUS, FLAG_BITS, 32'h0);
    tk(1); rxb <= 1'b1; tk(1); rxb <= 1'b0;
    rdchk("wdog_over", OFS_STATUS, FLAG_BITS, 32'h200);
    bus(1'b1, OFS_STATUS, 32'h200);
  endtask
  task t_irq;
    be <= 4'h1;
    bus(1'b1, OFS_MASK, MASK_BITS);
    be <= 4'hF;
    rdchk("mask_lane", OFS_MASK, 32'hFFFFFFFF, 32'h000000C7);
    bus(1'b1, OFS_MASK, MASK_BITS);
    rdchk("mask", OFS_MASK, 32'hFFFFFFFF, MASK_BITS);
    tk(1); txst <= 3'h0; tk(4); chk("irq_set", 32'h1, irq);
    rdchk("summary", OFS_STATUS, MASK_BITS, 32'h8002);
    bus(1'b1, OFS_STATUS, 32'h2);
    tk(3); chk("irq_clear", 0, irq);
    bus(1'b1, OFS_MASK, 32'h0);
    tk(1); rxst <= 3'h0; tk(4); chk("irq_masked", 32'h0, irq);
    rdchk("summary_masked", OFS_STATUS, MASK_BITS, 32'h100);
  endtask
  initial
  begin
    {rst_n_i, rd, wr, txf, txs, txb, rxf, rxa, rxb, rxr, rxw} = 11'h0;
    {addr, wd, txst, rxst, give, take} = 46'h0;
    be = 4'hF;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    tk(12);
    rst_n_i <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_wdog();
    t_irq();
    give_verdict();
  end
endmodule
`default_nettype wire
